// >>> core/pwmsy_regs.svh
`ifndef PWMSY_REGS_SVH
`define PWMSY_REGS_SVH

// register word addresses
`define PWMSY_ADDR_TBCTL   8'h00
`define PWMSY_ADDR_PERIOD  8'h01
`define PWMSY_ADDR_DUTY    8'h02
`define PWMSY_ADDR_ROLL    8'h03
`define PWMSY_ADDR_TBCNT   8'h04
`define PWMSY_ADDR_PHASE   8'h10
`define PWMSY_ADDR_TRGCMP  8'h14
`define PWMSY_ADDR_TRGCON  8'h18
`define PWMSY_GEN_SEL_MASK 8'hFC

// time_base_control fields
`define PWMSY_TB_EN_BIT    15
`define PWMSY_POL_BIT      9
`define PWMSY_SOEN_BIT     8
`define PWMSY_SIEN_BIT     7
`define PWMSY_SRC_HI       6
`define PWMSY_SRC_LO       4

// trigger_control_reg fields
`define PWMSY_DIV_HI       15
`define PWMSY_DIV_LO       13
`define PWMSY_START_HI     5
`define PWMSY_START_LO     0

// reset values
`define PWMSY_TBCTL_RST    16'h0000
`define PWMSY_PERIOD_RST   16'hFFF0
`define PWMSY_ZERO16       16'h0000

// timing
`define PWMSY_CLK_NS       100
`define PWMSY_SYNC_PULSE_NS 100
`define PWMSY_SYNC_CYCLES  ((`PWMSY_SYNC_PULSE_NS + `PWMSY_CLK_NS - 1) / `PWMSY_CLK_NS)

`endif

// >>> core/pwmsy_pkg.sv
package pwmsy_pkg;

	typedef struct packed {
		logic [2:0] div;
		logic [5:0] start;
	} pwmsy_trgctl_t;

	typedef struct packed {
		logic       tb_en;
		logic       pol;
		logic       out_en;
		logic       in_en;
		logic [2:0] src;
	} pwmsy_tbctl_t;

	typedef enum logic [1:0] {
		PWMSY_IDLE  = 2'h0,
		PWMSY_PULSE = 2'h1
	} pwmsy_sync_state_t;

endpackage

// >>> core/pwmsy_sync.sv
`timescale 1ns/1ns
`include "pwmsy_regs.svh"
module pwmsy_sync
	import pwmsy_pkg::*;
#(
	parameter int NSRC = 8
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// control
	input  wire pwmsy_tbctl_t      ctl,
	input  wire logic [NSRC-1:0]   sync_sources,
	input  wire logic              rollover,
	// results
	output logic                   sync_hit,
	output logic                   sync_output
);
	localparam int CW = 4;
	localparam logic [CW-1:0] PULSE_CYC = CW'(`PWMSY_SYNC_CYCLES);

	pwmsy_sync_state_t state;
	logic [CW-1:0]     cnt;
	logic              prev;

	wire logic sync_input  = sync_sources[ctl.src];
	wire logic rise        = sync_input & ~prev;
	wire logic fall        = ~sync_input & prev;
	wire logic active_edge = ctl.pol ? fall : rise;
	wire logic next_hit    = ctl.in_en & active_edge;
	wire logic start       = ctl.out_en & rollover;
	wire logic pulsing     = (state == PWMSY_PULSE);
	wire logic next_out    = pulsing ^ ctl.pol;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prev     <= 1'b0;
			sync_hit <= 1'b0;
		end else begin
			prev     <= sync_input;
			sync_hit <= next_hit;
		end
	end

	// fixed-length output pulse
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= PWMSY_IDLE;
			cnt   <= '0;
		end else begin
			case (state)
				PWMSY_IDLE: begin
					if (start) begin
						state <= PWMSY_PULSE;
						cnt   <= PULSE_CYC;
					end
				end
				PWMSY_PULSE: begin
					cnt <= cnt - 1'b1;
					if (cnt == CW'(1)) begin
						state <= PWMSY_IDLE;
					end
				end
				default: state <= PWMSY_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync_output <= 1'b0;
		end else begin
			sync_output <= next_out;
		end
	end

	// assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	edge_pick_a:
		assert property (ctl.in_en && active_edge |=> sync_hit)
		else $error("active sync edge not taken");
	edge_gate_a:
		assert property (!ctl.in_en |=> !sync_hit)
		else $error("sync input taken while disabled");
	pulse_len_a:
		assert property (state == PWMSY_IDLE && start |=> pulsing [*1] ##1 !pulsing)
		else $error("sync output pulse length wrong");
	out_level_a:
		assert property (!pulsing && $stable(ctl.pol) |=> sync_output == $past(ctl.pol))
		else $error("sync output idle level wrong");
	edge_cov_c: cover property (sync_hit);
endmodule // pwmsy_sync

// >>> core/pwmsy_trig_gen.sv
`timescale 1ns/1ns
module pwmsy_trig_gen
	import pwmsy_pkg::*;
#(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          nrst,
	// time base
	input  wire logic          tb_run,
	input  wire logic [W-1:0]  tb_cnt,
	input  wire logic [W-1:0]  period,
	input  wire logic [5:0]    roll_count,
	// shared duty, then per-generator settings
	input  wire logic [W-1:0]  duty,
	input  wire logic [W-1:0]  phase,
	input  wire logic [W-1:0]  trig_cmp,
	input  wire pwmsy_trgctl_t trgctl,
	input  wire logic          trgctl_wr,
	// outputs
	output logic               pwm_out,
	output logic               trig_out
);
	logic       armed;
	logic [2:0] div_cnt;

	// counter seen by this generator, shifted back by the phase offset
	wire logic [W:0]   wrap_sum = {1'b0, tb_cnt} + {1'b0, period} + 1'b1 - {1'b0, phase};
	wire logic [W-1:0] ph_cnt   = (tb_cnt >= phase) ? (tb_cnt - phase) : wrap_sum[W-1:0];
	wire logic         next_pwm = tb_run & (ph_cnt < duty);
	wire logic         start_eq = (roll_count == trgctl.start);
	wire logic         match    = tb_run & armed & (ph_cnt == trig_cmp);
	wire logic         div_done = (div_cnt == trgctl.div);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			armed <= 1'b0;
		end else if (trgctl_wr) begin
			armed <= 1'b0;
		end else if (start_eq) begin
			armed <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt  <= 3'h0;
			trig_out <= 1'b0;
			pwm_out  <= 1'b0;
		end else begin
			pwm_out  <= next_pwm;
			trig_out <= match & div_done;
			if (trgctl_wr) begin
				div_cnt <= 3'h0;
			end else if (match) begin
				div_cnt <= div_done ? 3'h0 : div_cnt + 3'h1;
			end
		end
	end

	// assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	hold_off_a:
		assert property (trig_out |-> $past(armed) && $past(ph_cnt) == $past(trig_cmp))
		else $error("trigger issued before start count reached");
	stay_armed_a:
		assert property (armed && !trgctl_wr |=> armed)
		else $error("trigger counting dropped without rewrite");
	div_count_a:
		assert property (match && div_cnt != trgctl.div && !trgctl_wr |=> !trig_out)
		else $error("trigger passed before divider count");
	phase_edge_a:
		assert property (tb_run && phase == '0 && tb_cnt < duty |=> pwm_out)
		else $error("pwm output not high inside duty window");
	trig_cov_c: cover property (trig_out);
endmodule // pwmsy_trig_gen

// >>> core/pwmsy_top.sv
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`include "pwmsy_regs.svh"
// What this block does
// - separate bits enable the sync input and the sync output
// - sync polarity bit picks rising or falling edge of sync input
// - same polarity bit makes the sync output pulse active high or low
// - three-bit source field picks which candidate drives the sync input
// - active sync edge resets the time base counter when input enabled
// - sync output pulses once per time base rollover when enabled
// - sync output pulse lasts about 100 ns
// - rollover counter increments each time the time base wraps
// - trigger divider passes one of every div+1 trigger matches to the ADC
// - trigger counting waits until rollover count equals the start value
// - phase offsets shift each generator's pwm edges
module pwmsy_top
	import pwmsy_pkg::*;
#(
	parameter int NGEN = 4,
	parameter int NSRC = 8,
	parameter int W    = 16
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [W-1:0]      reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [W-1:0]      reg_rdata,
	// synchronization
	input  wire logic [NSRC-1:0]   sync_sources,
	output logic                   sync_output,
	// generator outputs
	output logic      [NGEN-1:0]   pwm_out,
	output logic      [NGEN-1:0]   adc_trigger
);
	logic [W-1:0]  time_base_control;
	logic [W-1:0]  period_value;
	logic [W-1:0]  duty;
	logic [W-1:0]  tb_cnt;
	logic [5:0]    roll_count;
	logic [W-1:0]  phase    [NGEN];
	logic [W-1:0]  trig_cmp [NGEN];
	pwmsy_trgctl_t trgctl   [NGEN];
	logic          sync_hit;

	// control fields
	pwmsy_tbctl_t  tbctl;
	assign tbctl.tb_en  = time_base_control[`PWMSY_TB_EN_BIT];
	assign tbctl.pol    = time_base_control[`PWMSY_POL_BIT];
	assign tbctl.out_en = time_base_control[`PWMSY_SOEN_BIT];
	assign tbctl.in_en  = time_base_control[`PWMSY_SIEN_BIT];
	assign tbctl.src    = time_base_control[`PWMSY_SRC_HI:`PWMSY_SRC_LO];

	// address decode
	wire logic [1:0] gsel     = reg_addr[1:0];
	wire logic [7:0] gbase    = reg_addr & `PWMSY_GEN_SEL_MASK;
	wire logic       wr_tbctl = reg_wr & (reg_addr == `PWMSY_ADDR_TBCTL);
	wire logic       wr_per   = reg_wr & (reg_addr == `PWMSY_ADDR_PERIOD);
	wire logic       wr_duty  = reg_wr & (reg_addr == `PWMSY_ADDR_DUTY);
	wire logic       wr_phase = reg_wr & (gbase == `PWMSY_ADDR_PHASE);
	wire logic       wr_tcmp  = reg_wr & (gbase == `PWMSY_ADDR_TRGCMP);
	wire logic       wr_tcon  = reg_wr & (gbase == `PWMSY_ADDR_TRGCON);

	// time base
	wire logic tb_run   = tbctl.tb_en;
	wire logic wrap     = tb_run & ~sync_hit & (tb_cnt >= period_value);
	wire logic [W-1:0] next_tb_cnt = (!tb_run || sync_hit || wrap) ? '0 : tb_cnt + 1'b1;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tb_cnt <= '0;
		end else begin
			tb_cnt <= next_tb_cnt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			roll_count <= 6'h00;
		end else if (wrap) begin
			roll_count <= roll_count + 6'h01;
		end
	end

	// shared registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			time_base_control <= `PWMSY_TBCTL_RST;
			period_value      <= `PWMSY_PERIOD_RST;
			duty              <= `PWMSY_ZERO16;
		end else begin
			if (wr_tbctl) time_base_control <= reg_wdata;
			if (wr_per)   period_value      <= reg_wdata;
			if (wr_duty)  duty              <= reg_wdata;
		end
	end

	// read mux
	logic [W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (reg_addr)
			`PWMSY_ADDR_TBCTL:  rd_mux = time_base_control;
			`PWMSY_ADDR_PERIOD: rd_mux = period_value;
			`PWMSY_ADDR_DUTY:   rd_mux = duty;
			`PWMSY_ADDR_ROLL:   rd_mux = W'(roll_count);
			`PWMSY_ADDR_TBCNT:  rd_mux = tb_cnt;
			default: begin
				if (gbase == `PWMSY_ADDR_PHASE)  rd_mux = phase[gsel];
				if (gbase == `PWMSY_ADDR_TRGCMP) rd_mux = trig_cmp[gsel];
				if (gbase == `PWMSY_ADDR_TRGCON) begin
					rd_mux[`PWMSY_DIV_HI:`PWMSY_DIV_LO]     = trgctl[gsel].div;
					rd_mux[`PWMSY_START_HI:`PWMSY_START_LO] = trgctl[gsel].start;
				end
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : '0;
		end
	end

	// sync input edge and output pulse
	pwmsy_sync #(
		.NSRC (NSRC)
	) u_sync (
		.ref_clk      (ref_clk),
		.nrst         (nrst),
		.ctl          (tbctl),
		.sync_sources (sync_sources),
		.rollover     (wrap),
		.sync_hit     (sync_hit),
		.sync_output  (sync_output)
	);

	// per-generator phase, trigger divider and stagger start
	for (genvar g = 0; g < NGEN; g++) begin : gen_g
		wire logic sel_g = (gsel == 2'(g));

		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				phase[g]    <= '0;
				trig_cmp[g] <= '0;
				trgctl[g]   <= '0;
			end else begin
				if (wr_phase && sel_g) phase[g] <= reg_wdata;
				if (wr_tcmp && sel_g)  trig_cmp[g] <= reg_wdata;
				if (wr_tcon && sel_g) begin
					trgctl[g].div   <= reg_wdata[`PWMSY_DIV_HI:`PWMSY_DIV_LO];
					trgctl[g].start <= reg_wdata[`PWMSY_START_HI:`PWMSY_START_LO];
				end
			end
		end

		pwmsy_trig_gen #(
			.W (W)
		) u_gen (
			.ref_clk    (ref_clk),
			.nrst       (nrst),
			.tb_run     (tb_run),
			.tb_cnt     (tb_cnt),
			.period     (period_value),
			.roll_count (roll_count),
			.duty       (duty),
			.phase      (phase[g]),
			.trig_cmp   (trig_cmp[g]),
			.trgctl     (trgctl[g]),
			.trgctl_wr  (wr_tcon && sel_g),
			.pwm_out    (pwm_out[g]),
			.trig_out   (adc_trigger[g])
		);
	end

	// assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sync_reset_a:
		assert property (sync_hit && tb_run |=> tb_cnt == '0)
		else $error("time base not reset by sync edge");
	roll_inc_a:
		assert property (wrap |=> roll_count == 6'($past(roll_count) + 6'h01))
		else $error("rollover counter did not advance");
	roll_hold_a:
		assert property (!wrap |=> $stable(roll_count))
		else $error("rollover counter moved without a wrap");
	sync_out_a:
		assert property (wrap && tbctl.out_en |=> ##1
			sync_output != $past(tbctl.pol))
		else $error("no sync output pulse on rollover");
	sync_quiet_a:
		assert property ((!tbctl.out_en && $stable(tbctl.pol)) [*3]
			|-> sync_output == tbctl.pol)
		else $error("sync output pulsed while disabled");
	sync_width_a:
		assert property (sync_output != tbctl.pol && $stable(tbctl.pol)
			|=> sync_output == $past(tbctl.pol))
		else $error("sync output pulse longer than one cycle");
	rd_timing_a:
		assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data outside its cycle");

	// register writes land and otherwise hold
	ctl_write_a:
		assert property (wr_tbctl |=> time_base_control == $past(reg_wdata))
		else $error("control write lost");
	ctl_hold_a:
		assert property (!wr_tbctl |=> $stable(time_base_control))
		else $error("control changed without a write");
	per_write_a:
		assert property (wr_per |=> period_value == $past(reg_wdata))
		else $error("period write lost");
	per_hold_a:
		assert property (!wr_per |=> $stable(period_value))
		else $error("period changed without a write");
	duty_write_a:
		assert property (wr_duty |=> duty == $past(reg_wdata))
		else $error("duty write lost");
	duty_hold_a:
		assert property (!wr_duty |=> $stable(duty))
		else $error("duty changed without a write");

	// read data carries the register of the strobe cycle
	rd_ctl_a:
		assert property (reg_rd && reg_addr == `PWMSY_ADDR_TBCTL
			|=> reg_rdata == $past(time_base_control))
		else $error("control read back wrong");
	rd_per_a:
		assert property (reg_rd && reg_addr == `PWMSY_ADDR_PERIOD
			|=> reg_rdata == $past(period_value))
		else $error("period read back wrong");
	rd_duty_a:
		assert property (reg_rd && reg_addr == `PWMSY_ADDR_DUTY
			|=> reg_rdata == $past(duty))
		else $error("duty read back wrong");
	rd_roll_a:
		assert property (reg_rd && reg_addr == `PWMSY_ADDR_ROLL
			|=> reg_rdata == W'($past(roll_count)))
		else $error("rollover count read back wrong");
	rd_count_a:
		assert property (reg_rd && reg_addr == `PWMSY_ADDR_TBCNT
			|=> reg_rdata == $past(tb_cnt))
		else $error("time base count read back wrong");
	rd_spare_a:
		assert property (reg_rd && gbase == `PWMSY_ADDR_TRGCON
			|=> reg_rdata[`PWMSY_DIV_LO-1:`PWMSY_START_HI+1] == '0)
		else $error("unused trigger control bits read nonzero");

	// time base
	tb_idle_a:
		assert property (!tb_run |=> tb_cnt == '0)
		else $error("time base counted while stopped");
	tb_step_a:
		assert property (tb_run && !sync_hit && !wrap |=> tb_cnt == $past(tb_cnt) + 1'b1)
		else $error("time base did not advance");
	tb_wrap_a:
		assert property (wrap |=> tb_cnt == '0)
		else $error("time base did not wrap after period");
	sync_first_a:
		assert property (sync_hit && tb_run && tb_cnt >= period_value
			|=> $stable(roll_count))
		else $error("rollover counted on a sync reset");

	// generator outputs rest while the time base is stopped
	pwm_stop_a:
		assert property (!tb_run |=> pwm_out == '0)
		else $error("pwm output high while stopped");
	trig_stop_a:
		assert property (!tb_run |=> adc_trigger == '0)
		else $error("adc trigger while stopped");

	// per-generator register writes
	for (genvar g = 0; g < NGEN; g++) begin : chk_g
		phase_write_a:
			assert property (@(posedge ref_clk) disable iff (!nrst)
				wr_phase && gsel == 2'(g) |=> phase[g] == $past(reg_wdata))
			else $error("phase write lost");
		cmp_write_a:
			assert property (@(posedge ref_clk) disable iff (!nrst)
				wr_tcmp && gsel == 2'(g) |=> trig_cmp[g] == $past(reg_wdata))
			else $error("trigger compare write lost");
		div_write_a:
			assert property (@(posedge ref_clk) disable iff (!nrst)
				wr_tcon && gsel == 2'(g)
				|=> trgctl[g].div == $past(reg_wdata[`PWMSY_DIV_HI:`PWMSY_DIV_LO]))
			else $error("trigger divider write lost");
		start_write_a:
			assert property (@(posedge ref_clk) disable iff (!nrst)
				wr_tcon && gsel == 2'(g)
				|=> trgctl[g].start == $past(reg_wdata[`PWMSY_START_HI:`PWMSY_START_LO]))
			else $error("trigger start write lost");
	end

	wrap_cov_c: cover property (wrap && tbctl.out_en);
	hit_cov_c:  cover property (sync_hit && tb_cnt != '0);
	stage_cov_c: cover property (adc_trigger[NGEN-1]);
endmodule // pwmsy_top

// >>> bench/pwmsy_partner.sv
`timescale 1ns/1ns
module pwmsy_partner #(
	parameter int NSRC = 8
) (
	// clock
	input  wire logic            ref_clk,
	// candidate sync lines
	output logic      [NSRC-1:0] sync_sources
);
	logic idle_lvl;

	initial begin
		idle_lvl = 1'b0;
		sync_sources = '0;
	end

	// every line rests at the level that makes the coming pulse edge the active one
	task automatic rest(input logic lvl);
		@(posedge ref_clk);
		idle_lvl = lvl;
		sync_sources <= {NSRC{lvl}};
	endtask

	// two cycles keeps the pulse beyond 100 ns
	task automatic pulse(input int idx);
		@(posedge ref_clk);
		sync_sources[idx] <= ~idle_lvl;
		repeat (2) @(posedge ref_clk);
		sync_sources[idx] <= idle_lvl;
	endtask
endmodule // pwmsy_partner

// >>> bench/pwmsy_top_test.sv
`timescale 1ns/1ns
`include "pwmsy_regs.svh"
module pwmsy_top_test
	import pwmsy_pkg::*;
;
	localparam logic [15:0] RUN  = 16'h0001 << `PWMSY_TB_EN_BIT;
	localparam logic [15:0] POL  = 16'h0001 << `PWMSY_POL_BIT;
	localparam logic [15:0] SOEN = 16'h0001 << `PWMSY_SOEN_BIT;
	localparam logic [15:0] SIEN = 16'h0001 << `PWMSY_SIEN_BIT;

	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [7:0]  sync_sources;
	logic        sync_output;
	logic [3:0]  pwm_out;
	logic [3:0]  adc_trigger;
	int          miscompares = 0;
	int          n_compared = 0;
	int          cyc = 0;
	logic [17:0] expq[$];
	logic        rd_d = 1'b0;
	logic [31:0] rnd = 32'h66D724C7;
	logic        so_on = 1'b0;
	logic        so_pol = 1'b0;
	int          so_last = -1;
	int          so_cnt = 0;
	logic        tg_on = 1'b0;
	int          tfirst[4];
	int          tlast[4];
	logic        pw_on = 1'b0;
	logic [1:0]  ph[4];
	logic [3:0]  hist = 4'h0;

	always #50 ref_clk = ~ref_clk;

	pwmsy_top #(.NGEN(4), .NSRC(8), .W(16)) pwmsy_top_i (
		.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sync_sources(sync_sources), .sync_output(sync_output),
		.pwm_out(pwm_out), .adc_trigger(adc_trigger));

	pwmsy_partner #(.NSRC(8)) pwmsy_partner_i (.ref_clk(ref_clk), .sync_sources(sync_sources));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// mode 0 equal, 1 below the value, 2 at least the value
	task automatic rd(input logic [7:0] a, input logic [1:0] m, input logic [15:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		expq.push_back({m, e});
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			test_done();
		end
	end

	// outputs are judged mid-cycle, after every edge has settled
	always @(negedge ref_clk) begin : watch
		logic [17:0] e;
		logic [3:0]  h;
		if (rd_d) begin
			e = expq.pop_front();
			case (e[17:16])
			2'h1: check({15'h0000, reg_rdata < e[15:0]}, 16'h0001);
			2'h2: check({15'h0000, reg_rdata >= e[15:0]}, 16'h0001);
			default: check(reg_rdata, e[15:0]);
			endcase
		end else if (reg_rdata !== 16'h0000)
			check(reg_rdata, 16'h0000);
		if (so_on && sync_output !== so_pol) begin
			if (so_last >= 0)
				check(16'(cyc - so_last), 16'h0004);
			so_last = cyc;
			so_cnt++;
		end
		for (int g = 0; g < 4; g++) begin
			if (tg_on && adc_trigger[g] === 1'b1) begin
				if (tlast[g] >= 0)
					check(16'(cyc - tlast[g]), 16'h0010);
				else if (g > 0)
					check(16'(cyc - tfirst[g - 1]), 16'h0004);
				if (tlast[g] < 0)
					tfirst[g] = cyc;
				tlast[g] = cyc;
			end
		end
		h = {hist[2:0], pwm_out[0]};
		if (pw_on) begin
			for (int g = 1; g < 4; g++)
				check(pwm_out[g], h[2'(ph[g] - ph[0])]);
			check(16'($countones(h)), 16'h0002);
		end
		hist = h;
	end

	initial begin
		for (int g = 0; g < 4; g++) begin
			tfirst[g] = -1;
			tlast[g] = -1;
			ph[g] = 2'h0;
		end
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		check(sync_output, 1'b0);
		rd(`PWMSY_ADDR_PERIOD, 2'h0, `PWMSY_PERIOD_RST);
		rd(`PWMSY_ADDR_TBCTL, 2'h0, `PWMSY_TBCTL_RST);
		rd(`PWMSY_ADDR_ROLL, 2'h0, 16'h0000);
		rd(8'h3F, 2'h0, 16'h0000);
		// staggered triggers: every fourth match, generator g starts at rollover g
		for (int g = 0; g < 4; g++) begin
			wr(`PWMSY_ADDR_TRGCMP + 8'(g), 16'h0002);
			wr(`PWMSY_ADDR_TRGCON + 8'(g), {3'h3, 7'h00, 6'(g)});
		end
		wr(`PWMSY_ADDR_PERIOD, 16'h0003);
		tg_on = 1'b1;
		wr(`PWMSY_ADDR_TBCTL, RUN);
		repeat (64) @(posedge ref_clk);
		wr(`PWMSY_ADDR_TBCTL, 16'h0000);
		tg_on = 1'b0;
		rd(`PWMSY_ADDR_ROLL, 2'h0, 16'h0010);
		check({15'h0000, tlast[3] >= 0}, 16'h0001);
		// sync output: bit 0 polarity, bit 1 output disabled
		for (int p = 0; p < 4; p++) begin
			wr(`PWMSY_ADDR_TBCTL, RUN | (p[0] ? POL : 16'h0000) | (p[1] ? 16'h0000 : SOEN));
			repeat (3) @(posedge ref_clk);
			so_pol = p[0];
			so_cnt = 0;
			so_last = -1;
			so_on = 1'b1;
			repeat (40) @(posedge ref_clk);
			so_on = 1'b0;
			check(16'(so_cnt), p[1] ? 16'h0000 : 16'h000A);
		end
		// random phases on a shared half duty
		wr(`PWMSY_ADDR_DUTY, 16'h0002);
		for (int g = 0; g < 4; g++) begin
			rnd = lfsr(rnd);
			ph[g] = rnd[1:0];
			wr(`PWMSY_ADDR_PHASE + 8'(g), {14'h0000, ph[g]});
		end
		repeat (8) @(posedge ref_clk);
		pw_on = 1'b1;
		repeat (24) @(posedge ref_clk);
		pw_on = 1'b0;
		// sync input: bit 0 polarity; pairs are hit, other line, input disabled
		wr(`PWMSY_ADDR_PERIOD, 16'h0040);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			wr(`PWMSY_ADDR_TBCTL, 16'h0000);
			pwmsy_partner_i.rest(k[0]);
			wr(`PWMSY_ADDR_TBCTL, RUN | (k[0] ? POL : 16'h0000) | (k < 4 ? SIEN : 16'h0000)
				| {9'h000, rnd[2:0], 4'h0});
			repeat (24) @(posedge ref_clk);
			pwmsy_partner_i.pulse({29'h0, k / 2 == 1 ? rnd[2:0] + 3'h1 : rnd[2:0]});
			rd(`PWMSY_ADDR_TBCNT, k < 2 ? 2'h1 : 2'h2, 16'h0008);
		end
		// reset in mid-run clears pulse and rollover count
		wr(`PWMSY_ADDR_PERIOD, 16'h0003);
		wr(`PWMSY_ADDR_TBCTL, RUN | SOEN);
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(sync_output, 1'b0);
		nrst <= 1'b1;
		rd(`PWMSY_ADDR_ROLL, 2'h0, 16'h0000);
		rd(`PWMSY_ADDR_TBCTL, 2'h0, `PWMSY_TBCTL_RST);
		repeat (3) @(posedge ref_clk);
		test_done();
	end
endmodule // pwmsy_top_test
